// *** verilog/ffau_unit.sv ***
// Float/fixed arithmetic unit: one-cycle registered datapath for add, subtract, multiply.
// Assumes the issue logic presents one request per cycle with a valid strobe.
`timescale 1ns/1ps
module ffau_unit
(
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  // Request from issue logic
  input  wire ffau_pkg::ffau_req_t i_req,
  // Result
  output ffau_pkg::ffau_rsp_t      o_rsp
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ffau_pkg::ffau_rsp_t rsp;
  } ffau_state_t;

  ffau_state_t state_r;
  ffau_state_t state_nxt;

  ffau_pkg::ffau_cls_t     cls_j;
  ffau_pkg::ffau_cls_t     cls_k;
  logic                    neg_j;
  logic                    neg_k;
  logic                    norm_j;
  logic                    norm_k;
  logic signed [12:0]      exp_j;
  logic signed [12:0]      exp_k;
  logic signed [48:0]      coef_j;
  logic signed [48:0]      coef_k;

  ffau_classify u_cls_j
  (
    .i_word (i_req.first_operand_register),
    .o_cls  (cls_j),
    .o_neg  (neg_j),
    .o_norm (norm_j),
    .o_exp  (exp_j),
    .o_coef (coef_j)
  );

  ffau_classify u_cls_k
  (
    .i_word (i_req.second_operand_register),
    .o_cls  (cls_k),
    .o_neg  (neg_k),
    .o_norm (norm_k),
    .o_exp  (exp_k),
    .o_coef (coef_k)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pack a signed coefficient and unbiased exponent, with range limits
  function automatic logic [59:0] pack_word(input logic signed [49:0] coef,
                                            input logic signed [14:0] exp);
    logic        neg;
    logic [47:0] mag;
    logic [11:0] pexp;
    logic [59:0] w;
    neg = coef[49];
    mag = neg ? 48'((-coef)) : coef[47:0];
    if (exp > 15'(ffau_pkg::EXP_MAX))
    begin
      pexp = ffau_pkg::EXP_POS_OVF;
      mag  = 48'h0;
    end
    else if (exp < 15'(ffau_pkg::EXP_MIN))
    begin
      pexp = ffau_pkg::EXP_POS_UNF;
      mag  = 48'h0;
    end
    else
    begin
      pexp = 12'(exp) + ffau_pkg::EXP_BIAS;
      if (exp < 15'sh0)
      begin
        pexp = 12'(exp) + ffau_pkg::EXP_BIAS - 12'h001;
      end
    end
    w = {pexp, mag};
    // Negative sign complements exponent and coefficient together
    if (neg)
    begin
      w = ~w;
    end
    return w;
  endfunction

  // One's complement add with end-around carry, overflow ignored
  function automatic logic [59:0] oc_add60(input logic [59:0] a, input logic [59:0] b);
    logic [60:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[59:0] + {59'h0, s[60]};
  endfunction

  function automatic logic [17:0] oc_add18(input logic [17:0] a, input logic [17:0] b);
    logic [18:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[17:0] + {17'h0, s[18]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [5:0]          op;
  logic                is_add;
  logic                is_mul;
  logic                sub;
  logic                dbl;
  logic                rnd;
  logic signed [48:0]  ck_eff;
  logic                nk_eff;
  logic signed [12:0]  e_big;
  logic signed [12:0]  e_dif;
  logic signed [97:0]  acc;
  logic signed [97:0]  small_sh;
  logic signed [97:0]  big_v;
  logic signed [14:0]  e_res;
  logic [59:0]         res;
  logic                ovf_j;
  logic                ovf_k;
  logic                unf_j;
  logic                unf_k;
  logic [47:0]         mag_j;
  logic [47:0]         mag_k;
  logic                neg_p;
  logic [95:0]         prod;

  always_comb
  begin
    op       = i_req.opcode;
    is_add   = (op >= ffau_pkg::OP_FADD) && (op <= ffau_pkg::OP_RSUB);
    is_mul   = (op >= ffau_pkg::OP_FMUL) && (op <= ffau_pkg::OP_DMUL);
    sub      = op[0] && is_add;
    dbl      = (op == ffau_pkg::OP_DADD) || (op == ffau_pkg::OP_DSUB) ||
               (op == ffau_pkg::OP_DMUL);
    rnd      = (op == ffau_pkg::OP_RADD) || (op == ffau_pkg::OP_RSUB) ||
               (op == ffau_pkg::OP_RMUL);
    ck_eff   = sub ? -coef_k : coef_k;
    nk_eff   = sub ? ~neg_k : neg_k;
    ovf_j    = cls_j == ffau_pkg::FFAU_OVF;
    ovf_k    = cls_k == ffau_pkg::FFAU_OVF;
    unf_j    = cls_j == ffau_pkg::FFAU_UNF;
    unf_k    = cls_k == ffau_pkg::FFAU_UNF;
    // Magnitudes from one's complement fields, sign handled apart
    mag_j    = i_req.first_operand_register[47:0] ^ {48{neg_j}};
    mag_k    = i_req.second_operand_register[47:0] ^ {48{neg_k}};
    neg_p    = neg_j ^ neg_k;
    prod     = 96'h0;
    acc      = 98'sh0;
    small_sh = 98'sh0;
    big_v    = 98'sh0;
    e_big    = (exp_j > exp_k) ? exp_j : exp_k;
    e_dif    = (exp_j > exp_k) ? (exp_j - exp_k) : (exp_k - exp_j);
    e_res    = 15'sh0;
    res      = ffau_pkg::WORD_ZERO;
    state_nxt         = state_r;
    state_nxt.rsp.valid = i_req.valid;

    if (is_add)
    begin
      // Smaller exponent's coefficient enters upper half, shifted right
      if (exp_j > exp_k)
      begin
        small_sh = ($signed({ck_eff, 48'h0})) >>> e_dif;
        big_v    = $signed({coef_j, 48'h0});
      end
      else
      begin
        small_sh = ($signed({coef_j, 48'h0})) >>> e_dif;
        big_v    = $signed({ck_eff, 48'h0});
      end
      // Rounding by operand bias keeps the same single-cycle path
      if (rnd)
      begin
        small_sh = small_sh + $signed({50'h0, 1'b1, 47'h0});
      end
      acc = small_sh + big_v;
      if (dbl)
      begin
        e_res = 15'(e_big) - 15'(ffau_pkg::PREC_SHIFT);
        res   = pack_word(acc[97] ? -$signed({2'b00, 48'((-acc))}) :
                          $signed({2'b00, acc[47:0]}), e_res);
      end
      else
      begin
        e_res = 15'(e_big);
        res   = pack_word(acc[97:48], e_res);
      end
      // Overflow operands dominate the arithmetic
      if (ovf_j || ovf_k)
      begin
        res = ((ovf_j ? neg_j : nk_eff)) ? {ffau_pkg::EXP_NEG_OVF, 48'hffffffffffff}
                                         : {ffau_pkg::EXP_POS_OVF, 48'h0};
        if (ovf_j && ovf_k && (neg_j != nk_eff))
        begin
          res = {ffau_pkg::EXP_POS_IND, 48'h0};
        end
      end
    end
    else if (is_mul)
    begin
      // Product of magnitudes keeps both halves exact for negative results
      prod = {48'h0, mag_j} * {48'h0, mag_k};
      if (rnd)
      begin
        prod = prod + {48'h0, 1'b1, 47'h0};
      end
      if ((op == ffau_pkg::OP_DMUL) && (exp_j == 13'sh0) && (exp_k == 13'sh0))
      begin
        if (norm_j && norm_k)
        begin
          res = neg_p ? {ffau_pkg::EXP_NEG_UNF, 48'hffffffffffff}
                      : ffau_pkg::WORD_ZERO;
        end
        else
        begin
          // Integer product, upper bits dropped without any flag
          res = {{12{prod[47]}}, prod[47:0]};
          if (neg_p)
          begin
            res = ~res;
          end
        end
      end
      else if (dbl)
      begin
        e_res = 15'(exp_j) + 15'(exp_k);
        res   = pack_word(neg_p ? -$signed({2'b00, prod[47:0]})
                                : $signed({2'b00, prod[47:0]}), e_res);
      end
      else
      begin
        e_res = 15'(exp_j) + 15'(exp_k) + 15'(ffau_pkg::PREC_SHIFT);
        // At most one leading zero when both inputs are normalized
        if (norm_j && norm_k && !prod[95])
        begin
          prod  = prod << 1;
          e_res = e_res - 15'sh1;
        end
        res   = pack_word(neg_p ? -$signed({2'b00, prod[95:48]})
                                : $signed({2'b00, prod[95:48]}), e_res);
      end
      if ((ovf_j && unf_k) || (unf_j && ovf_k))
      begin
        res = {ffau_pkg::EXP_POS_IND, 48'h0};
      end
      else if (ovf_j || ovf_k)
      begin
        res = (neg_j ^ neg_k) ? {ffau_pkg::EXP_NEG_OVF, 48'hffffffffffff}
                              : {ffau_pkg::EXP_POS_OVF, 48'h0};
      end
      else if (unf_j || unf_k)
      begin
        res = (neg_j ^ neg_k) ? {ffau_pkg::EXP_NEG_UNF, 48'hffffffffffff}
                              : ffau_pkg::WORD_ZERO;
      end
    end
    else if ((op == ffau_pkg::OP_LADD) || (op == ffau_pkg::OP_LSUB))
    begin
      res = oc_add60(i_req.first_operand_register,
                     op[0] ? ~i_req.second_operand_register
                           : i_req.second_operand_register);
    end
    else if ((op >= ffau_pkg::OP_INC_LO) && (op <= ffau_pkg::OP_INC_HI))
    begin
      res = {42'h0, oc_add18(i_req.first_operand_register[17:0],
                             op[0] ? ~i_req.second_operand_register[17:0]
                                   : i_req.second_operand_register[17:0])};
    end

    // Indefinite operand overrides every float result
    if ((is_add || is_mul) && ((cls_j == ffau_pkg::FFAU_IND) ||
                               (cls_k == ffau_pkg::FFAU_IND)))
    begin
      res = {ffau_pkg::EXP_POS_IND, 48'h0};
    end
    state_nxt.rsp.result = res;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign o_rsp = state_r.rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic is_f;
  assign is_f = ((i_req.opcode >= ffau_pkg::OP_FADD) && (i_req.opcode <= ffau_pkg::OP_RSUB)) ||
                ((i_req.opcode >= ffau_pkg::OP_FMUL) && (i_req.opcode <= ffau_pkg::OP_DMUL));

  property p_ind_in;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && is_f && (i_req.first_operand_register[59:48] == ffau_pkg::EXP_NEG_IND))
    |=> (o_rsp.result == {ffau_pkg::EXP_POS_IND, 48'h0});
  endproperty
  a_ind_in: assert property (p_ind_in) else $error("indefinite not propagated");

  property p_valid;
    @(posedge i_mclk) disable iff (i_rst)
    i_req.valid |=> o_rsp.valid;
  endproperty
  a_valid: assert property (p_valid) else $error("result valid missing");

  property p_ladd;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_LADD &&
     i_req.second_operand_register == 60'h0 &&
     i_req.first_operand_register != 60'hfffffffffffffff)
    |=> (o_rsp.result == $past(i_req.first_operand_register));
  endproperty
  a_ladd: assert property (p_ladd) else $error("long add of zero wrong");

  property p_inc_hi;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_INC_LO) |=> (o_rsp.result[59:18] == 42'h0);
  endproperty
  a_inc_hi: assert property (p_inc_hi) else $error("increment upper bits set");

  property p_ovf_add;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_FADD &&
     i_req.first_operand_register[59:48] == ffau_pkg::EXP_POS_OVF &&
     i_req.second_operand_register[59:48] == 12'h400)
    |=> (o_rsp.result[59:48] == ffau_pkg::EXP_POS_OVF);
  endproperty
  a_ovf_add: assert property (p_ovf_add) else $error("overflow add lost");

  property p_ovf_unf;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_FMUL &&
     i_req.first_operand_register[59:48] == ffau_pkg::EXP_POS_OVF &&
     i_req.second_operand_register[59:48] == ffau_pkg::EXP_POS_UNF)
    |=> (o_rsp.result == {ffau_pkg::EXP_POS_IND, 48'h0});
  endproperty
  a_ovf_unf: assert property (p_ovf_unf) else $error("ovf times unf not indefinite");

  property p_unf_mul;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_FMUL &&
     i_req.first_operand_register[59:48] == ffau_pkg::EXP_POS_UNF &&
     i_req.second_operand_register[59:48] == 12'h400)
    |=> (o_rsp.result == 60'h0);
  endproperty
  a_unf_mul: assert property (p_unf_mul) else $error("underflow product not zero");

  property p_imul;
    @(posedge i_mclk) disable iff (i_rst)
    (i_req.valid && i_req.opcode == ffau_pkg::OP_DMUL &&
     i_req.first_operand_register == 60'h400000000000003 &&
     i_req.second_operand_register == 60'h400000000000005)
    |=> (o_rsp.result == 60'h00000000000000f);
  endproperty
  a_imul: assert property (p_imul) else $error("integer multiply wrong");

  c_fadd: cover property (@(posedge i_mclk) disable iff (i_rst)
    i_req.valid && i_req.opcode == ffau_pkg::OP_FADD);
  c_dmul: cover property (@(posedge i_mclk) disable iff (i_rst)
    i_req.valid && i_req.opcode == ffau_pkg::OP_DMUL);
  c_ind: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_rsp.valid && o_rsp.result == {ffau_pkg::EXP_POS_IND, 48'h0});

endmodule // ffau_unit

// *** include/ffau_pkg.sv ***
// Package for the float/fixed arithmetic unit: opcodes, word layout, special forms.
// Assumes a 60-bit word with a 12-bit packed exponent above a 48-bit coefficient.
package ffau_pkg;

  localparam int WORD_W   = 60;
  localparam int COEF_W   = 48;
  localparam int EXP_W    = 12;
  localparam int SIGN_BIT = 59;
  localparam int NORM_BIT = 47;
  localparam int SHORT_W  = 18;

  // Opcodes (octal as printed)
  localparam logic [5:0] OP_FADD   = 6'o30;
  localparam logic [5:0] OP_FSUB   = 6'o31;
  localparam logic [5:0] OP_DADD   = 6'o32;
  localparam logic [5:0] OP_DSUB   = 6'o33;
  localparam logic [5:0] OP_RADD   = 6'o34;
  localparam logic [5:0] OP_RSUB   = 6'o35;
  localparam logic [5:0] OP_LADD   = 6'o36;
  localparam logic [5:0] OP_LSUB   = 6'o37;
  localparam logic [5:0] OP_FMUL   = 6'o40;
  localparam logic [5:0] OP_RMUL   = 6'o41;
  localparam logic [5:0] OP_DMUL   = 6'o42;
  localparam logic [5:0] OP_INC_LO = 6'o50;
  localparam logic [5:0] OP_INC_HI = 6'o77;

  // Packed upper exponent patterns
  localparam logic [11:0] EXP_POS_OVF = 12'hfff >> 1;   // 3777 octal
  localparam logic [11:0] EXP_NEG_OVF = 12'h800;        // 4000 octal
  localparam logic [11:0] EXP_POS_IND = 12'h3ff;        // 1777 octal
  localparam logic [11:0] EXP_NEG_IND = 12'hc00;        // 6000 octal
  localparam logic [11:0] EXP_POS_UNF = 12'h000;        // 0000 octal
  localparam logic [11:0] EXP_NEG_UNF = 12'hfff;        // 7777 octal
  localparam logic [11:0] EXP_BIAS    = 12'h400;        // 2000 octal

  // Unbiased exponent limits and precision shift
  localparam int EXP_MAX   = 1023;                      // positive 1777 octal
  localparam int EXP_MIN   = -1023;
  localparam int PREC_SHIFT = 48;                       // 60 octal

  localparam logic [59:0] WORD_ZERO = 60'h0;

  typedef enum logic [1:0] {FFAU_ORD, FFAU_OVF, FFAU_UNF, FFAU_IND} ffau_cls_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  opcode;
    logic [59:0] first_operand_register;
    logic [59:0] second_operand_register;
  } ffau_req_t;

  typedef struct packed {
    logic        valid;
    logic [59:0] result;
  } ffau_rsp_t;

endpackage

// *** verilog/ffau_classify.sv ***
// Operand classifier: class, sign, unbiased exponent and coefficient of a packed word.
// Assumes a packed operand in the upper-digit format of ffau_pkg.
`timescale 1ns/1ps
module ffau_classify
(
  // Operand
  input  wire logic [59:0]        i_word,
  // Decoded fields
  output ffau_pkg::ffau_cls_t     o_cls,
  output logic                    o_neg,
  output logic                    o_norm,
  output logic signed [12:0]      o_exp,
  output logic signed [48:0]      o_coef
);

  logic [11:0] upper;
  logic [11:0] true_exp;

  always_comb
  begin
    o_neg    = i_word[ffau_pkg::SIGN_BIT];
    upper    = i_word[59:48];
    // Negative coefficients complement the packed exponent
    true_exp = o_neg ? ~upper : upper;
    o_exp    = $signed({1'b0, true_exp}) - $signed(13'h3ff) - 13'sh1;
    if (!true_exp[10])
    begin
      o_exp = $signed({1'b0, true_exp}) - $signed(13'h3ff);
    end
    // Coefficient as signed value from one's complement 48-bit field
    o_coef = o_neg ? -$signed({1'b0, ~i_word[47:0]}) : $signed({1'b0, i_word[47:0]});
    o_norm = i_word[ffau_pkg::SIGN_BIT] != i_word[ffau_pkg::NORM_BIT];
    // Class decoded ahead of any coefficient work
    if ((upper == ffau_pkg::EXP_POS_IND) || (upper == ffau_pkg::EXP_NEG_IND))
    begin
      o_cls = ffau_pkg::FFAU_IND;
    end
    else if ((upper == ffau_pkg::EXP_POS_OVF) || (upper == ffau_pkg::EXP_NEG_OVF))
    begin
      o_cls = ffau_pkg::FFAU_OVF;
    end
    else if ((upper == ffau_pkg::EXP_POS_UNF) || (upper == ffau_pkg::EXP_NEG_UNF))
    begin
      o_cls = ffau_pkg::FFAU_UNF;
    end
    else
    begin
      o_cls = ffau_pkg::FFAU_ORD;
    end
  end

endmodule // ffau_classify

// *** dv/ffau_issue_model.sv ***
// Issue-side model: presents one request per call to the arithmetic unit.
// Assumes the unit samples i_req on the rising edge of i_mclk.
`timescale 1ns/1ps
module ffau_issue_model
(
  // Clock
  input  wire logic           i_mclk,
  // Request to the unit
  output ffau_pkg::ffau_req_t o_req
);
  initial o_req = '0;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle cycles carry junk fields so that a unit ignoring valid is caught
  task automatic issue(input logic v, input logic [5:0] op,
                       input logic [59:0] a, input logic [59:0] b);
    @(posedge i_mclk);
    #1;
    o_req = '{valid: v, opcode: op, first_operand_register: a,
              second_operand_register: b};
  endtask
endmodule // ffau_issue_model

// *** dv/test_float_fixed_arith_unit.sv ***
// Self-checking bench for the float/fixed arithmetic unit, random and corner cases.
// Assumes the unit answers every request from its output register on the same edge that takes it.
`timescale 1ns/1ps
module test_float_fixed_arith_unit;
  logic                i_mclk;
  logic                i_rst;
  ffau_pkg::ffau_req_t req;
  ffau_pkg::ffau_rsp_t rsp;
  int                  n_mismatch;
  int                  compares;
  int                  seed;
  int                  e1;
  int                  e2;
  logic                sent;
  logic [47:0]         c1;
  logic [47:0]         c2;
  logic [59:0]         a;
  logic [59:0]         b;
  logic [59:0]         w;
  logic [59:0]         p;
  logic [119:0]        exp_q[$];
  localparam logic [59:0] FULL = '1;
  localparam logic [59:0] TOP  = {12'hfff, 48'h0};
  localparam logic [59:0] IND  = {ffau_pkg::EXP_POS_IND, 48'h0};

  ffau_issue_model i_ffau_issue_model (.i_mclk(i_mclk), .o_req(req));
  ffau_unit i_ffau_unit (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(req), .o_rsp(rsp));

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [59:0] r60();
    return 60'({$random(seed), $random(seed)});
  endfunction

  // Biased packing of a positive word
  function automatic logic [59:0] pk(input int e, input logic [47:0] c);
    return {(e >= 0) ? 12'(e + 1024) : 12'(e + 1023), c};
  endfunction

  function automatic logic [59:0] oc60(input logic [59:0] x, input logic [59:0] y);
    logic [60:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[59:0] + 60'(s[60]);
  endfunction

  function automatic logic [17:0] oc18(input logic [17:0] x, input logic [17:0] y);
    logic [18:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[17:0] + 18'(s[18]);
  endfunction

  // Single multiply of positive normalized coefficients
  function automatic logic [59:0] fmul(input int ea, input int eb,
                                       input logic [47:0] ca, input logic [47:0] cb);
    logic [95:0] q;
    int          e;
    q = {48'h0, ca} * {48'h0, cb};
    e = ea + eb + 48;
    if (!q[95])
    begin
      q = q << 1;
      e = e - 1;
    end
    return pk(e, q[95:48]);
  endfunction

  // Add with ea the larger exponent
  function automatic logic [59:0] fadd(input int ea, input int eb, input logic [47:0] ca,
                                       input logic [47:0] cb, input logic dbl);
    logic [95:0] acc;
    acc = {cb, 48'h0} >> (ea - eb);
    acc[95:48] = acc[95:48] + ca;
    return dbl ? pk(ea - 48, acc[47:0]) : pk(ea, acc[95:48]);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_valid(input logic v);
    compares++;
    if (rsp.valid !== v)
    begin
      n_mismatch++;
      $display("MISMATCH %0t valid %b expected %b", $time, rsp.valid, v);
    end
  endtask

  task automatic check_result(input logic [119:0] e);
    compares++;
    if ((rsp.result & e[119:60]) !== e[59:0])
    begin
      n_mismatch++;
      $display("MISMATCH %0t result %h expected %h", $time, rsp.result, e[59:0]);
    end
  endtask

  task automatic op(input logic [5:0] o, input logic [59:0] x, input logic [59:0] y,
                    input logic [59:0] m, input logic [59:0] e);
    exp_q.push_back({m, e & m});
    i_ffau_issue_model.issue(1'b1, o, x, y);
  endtask

  task automatic idle();
    i_ffau_issue_model.issue(1'b0, 6'(r60()), r60(), r60());
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Requests change 1 ns after the edge, so the edge value is the taken one
  always @(posedge i_mclk)
  begin
    sent = req.valid;
    #2;
    if (!i_rst)
    begin
      check_valid(sent);
      if (sent && exp_q.size() > 0)
        check_result(exp_q.pop_front());
    end
  end

  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    seed = 32'h1c1f67a4;
    n_mismatch = 0;
    compares = 0;
    i_rst = 1'b1;
    repeat (6) @(posedge i_mclk);
    check_result({FULL, 60'h0});
    check_valid(1'b0);
    #1 i_rst = 1'b0;
    repeat (8)
    begin
      a = r60();
      b = r60();
      op(ffau_pkg::OP_LADD, a, b, FULL, oc60(a, b));
      op(ffau_pkg::OP_LSUB, a, b, FULL, oc60(a, ~b));
    end
    for (int o = 8'o50; o <= 8'o77; o++)
    begin
      a = 60'(r60() & 60'h3ffff);
      b = (o == 8'o50) ? 60'h3ffff : 60'(r60() & 60'h3ffff);
      w = 60'(oc18(a[17:0], o[0] ? ~b[17:0] : b[17:0]));
      op(6'(o), a, b, 60'h3ffff, w);
    end
    repeat (12)
    begin
      e1 = $random(seed) % 200;
      e2 = $random(seed) % 200;
      c1 = {1'b1, 47'(r60())};
      c2 = {1'b1, 47'(r60())};
      a = pk(e1, c1);
      b = pk(e2, c2);
      w = fmul(e1, e2, c1, c2);
      if (c1[0]) a = ~a;
      if (c2[0]) b = ~b;
      if (c1[0] ^ c2[0]) w = ~w;
      op(ffau_pkg::OP_FMUL, a, b, FULL, w);
      op(ffau_pkg::OP_RMUL, a, b, TOP, w);
      idle();
    end
    repeat (12)
    begin
      e1 = 100 + ($random(seed) & 255);
      e2 = e1 - 1 - ($random(seed) & 31);
      c1 = {3'b001, 45'(r60())};
      c2 = {3'b001, 45'(r60())};
      a = pk(e1, c1);
      b = pk(e2, c2);
      if (c1[1])
      begin
        w = a;
        a = b;
        b = w;
      end
      op(ffau_pkg::OP_FADD, a, b, FULL, fadd(e1, e2, c1, c2, 1'b0));
      op(ffau_pkg::OP_DADD, a, b, FULL, fadd(e1, e2, c1, c2, 1'b1));
      op(ffau_pkg::OP_RADD, a, b, TOP, fadd(e1, e2, c1, c2, 1'b0));
    end
    c1 = {1'b1, 47'(r60())};
    w = pk(10, c1);
    op(ffau_pkg::OP_FMUL, pk(1000, c1), pk(1000, c1), FULL, {12'h7ff, 48'h0});
    op(ffau_pkg::OP_FMUL, pk(-1000, c1), pk(-1000, c1), FULL, 60'h0);
    op(ffau_pkg::OP_FMUL, {12'h7ff, c1}, {12'h000, c1}, FULL, IND);
    op(ffau_pkg::OP_DMUL, pk(5, '1), pk(7, '1), FULL, pk(12, 48'h1));
    for (int o = 8'o30; o <= 8'o34; o += 2)
    begin
      op(6'(o), w, {12'h7ff, 48'h0}, TOP, {12'h7ff, 48'h0});
      op(6'(o), {12'h800, c1}, w, TOP, {12'h800, 48'h0});
      op(6'(o), w, {12'h3ff, c1}, FULL, IND);
    end
    op(ffau_pkg::OP_FADD, {12'hc00, c1}, w, FULL, IND);
    op(ffau_pkg::OP_FMUL, w, {12'hc00, c1}, FULL, IND);
    op(ffau_pkg::OP_FADD, {12'h7ff, c1}, pk(0, c1), TOP, {12'h7ff, 48'h0});
    op(ffau_pkg::OP_FMUL, {12'h000, c1}, pk(0, c1), FULL, 60'h0);
    op(ffau_pkg::OP_DMUL, 60'h400000000000003, 60'h400000000000005, FULL, 60'hf);
    op(ffau_pkg::OP_LADD, w, 60'h0, FULL, w);
    repeat (6)
    begin
      a = {12'h400, 28'h0, 20'(r60())};
      b = {12'h400, 28'h0, 20'(r60())};
      p = a[47:0] * b[47:0];
      op(ffau_pkg::OP_DMUL, a, b, FULL, p);
      a = {12'h400, 18'h0, 30'(r60())};
      b = {12'h400, 18'h0, 30'(r60())};
      p = a[47:0] * b[47:0];
      op(ffau_pkg::OP_DMUL, a, b, FULL, {{12{p[47]}}, p[47:0]});
    end
    op(ffau_pkg::OP_DMUL, pk(0, c1), pk(0, c1), TOP, 60'h0);
    repeat (4) idle();
    if (exp_q.size() != 0)
    begin
      n_mismatch++;
      $display("MISMATCH %0t answers missing", $time);
    end
    close_out();
  end
endmodule // test_float_fixed_arith_unit
